// file: rcc_regs.sv
// Notes on behaviour
// - retried master not back within 2^15 clocks sets its expired flag
// - expired flags stay set until software writes one to that bit
// - status bit 7 enables host retry counter, resets to one
// - status bit 6 enables card retry counter, resets to one
// - status bit 5 flags card target B expiry, write one clears
// - status bit 3 flags card target A expiry, write one clears
// - status bit 1 flags host target expiry, write one clears
// - status bits 4, 2, 0 always read zero
// - control bit 7 gates ring output to power pin or multipurpose pins
// - ring output enable is one bit shared by both functions
// - control bit 6 puts that socket's video pins in high impedance
// - both sockets in video mode: socket 0's bit 5 picks which select signals priority
// - control bits 4 and 3 always read zero
// - bit 2 routes socket audio to pwm pin, socket 0 wins
// - bit 1 routes speaker; output is xor of both sockets
// - speaker pin driven only while some function enables it
// - bit 0 set per socket on card functional interrupt
// - functional interrupt flag stays set until written with one
`include "rcc_defs.svh"

module rcc_regs
    import rcc_pkg::*;
#(
    parameter int unsigned RETRY_LIMIT = `RCC_RETRY_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_func,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic [2:0] retry_issue,
    input wire logic [2:0] master_back,
    input wire logic [1:0] card_irq_in,
    input wire logic [1:0] card_speaker_in,
    input wire logic [1:0] card_audio_in,
    input wire logic ring_in,
    input wire logic ring_pin_select,
    output logic power_event_out,
    output logic ring_indicate_out,
    output logic [1:0] video_port_hiz,
    output logic video_select_0,
    output logic video_select_1,
    output logic card_audio_pwm_out,
    output logic speaker_out_pin,
    output logic speaker_out_oe
);

    // ----------------------------------------------------------------
    // retry timers: 0 host target, 1 card target A, 2 card target B
    // ----------------------------------------------------------------
    rcc_state_s q, d;
    logic [2:0] exp_pulse;
    logic [2:0] timer_en;

    assign timer_en = {q.card_en, q.card_en, q.host_en};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_timer
            rcc_retry_timer #(
                .LIMIT(RETRY_LIMIT)
            ) u_timer (
                .clk(clk),
                .nrst(nrst),
                .enable(timer_en[gi]),
                .retry_issue(retry_issue[gi]),
                .master_back(master_back[gi]),
                .expire(exp_pulse[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // decode and read views
    // ----------------------------------------------------------------
    logic wr_status, wr_card, rd_status, rd_card;
    logic [7:0] status_view, card_view;

    // function 1 writes to the status offset are accepted; software is
    // expected to use function 0 only, so no filtering is done here
    assign wr_status = cfg_wr && (cfg_addr == `RCC_RETRY_STATUS_OFS);
    assign wr_card = cfg_wr && (cfg_addr == `RCC_CARD_CTRL_OFS);
    assign rd_status = cfg_rd && (cfg_addr == `RCC_RETRY_STATUS_OFS);
    assign rd_card = cfg_rd && (cfg_addr == `RCC_CARD_CTRL_OFS);

    always_comb
    begin
        status_view = 8'h00;
        status_view[`RCC_HOST_EN_BIT] = q.host_en;
        status_view[`RCC_CARD_EN_BIT] = q.card_en;
        status_view[`RCC_EXP_B_BIT] = q.expired[2];
        status_view[`RCC_EXP_A_BIT] = q.expired[1];
        status_view[`RCC_EXP_HOST_BIT] = q.expired[0];
        card_view = 8'h00;
        card_view[`RCC_RING_EN_BIT] = q.ring_en;
        card_view[`RCC_VIDEO_EN_BIT] = q.video_en[cfg_func];
        card_view[`RCC_PORT_SEL_BIT] = q.port_sel[cfg_func];
        card_view[`RCC_AUDIO_EN_BIT] = q.aud_en[cfg_func];
        card_view[`RCC_SPK_EN_BIT] = q.spk_en[cfg_func];
        card_view[`RCC_IRQ_FLAG_BIT] = q.irq_flag[cfg_func];
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [2:0] exp_clr;
    logic [1:0] irq_clr;
    logic [1:0] irq_lvl, spk_lvl, aud_lvl, spk_gated;

    assign exp_clr = wr_status ? {cfg_wdata[`RCC_EXP_B_BIT], cfg_wdata[`RCC_EXP_A_BIT],
                                  cfg_wdata[`RCC_EXP_HOST_BIT]} : 3'h0;
    assign irq_clr = (wr_card && cfg_wdata[`RCC_IRQ_FLAG_BIT]) ?
                     (cfg_func ? 2'h2 : 2'h1) : 2'h0;
    assign irq_lvl = q.flt[`RCC_PIN_IRQ +: 2];
    assign spk_lvl = q.flt[`RCC_PIN_SPK +: 2];
    assign aud_lvl = q.flt[`RCC_PIN_AUD +: 2];
    assign spk_gated = spk_lvl & q.spk_en;

    always_comb
    begin
        d = q;
        // pins pass three stages; a change counts once stages 2 and 3 agree
        d.sync1 = {ring_in, card_audio_in, card_speaker_in, card_irq_in};
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        for (int i = 0; i < `RCC_NUM_PINS; i++)
        begin
            if (q.sync2[i] == q.sync3[i])
                d.flt[i] = q.sync3[i];
        end

        // set wins over a clear landing in the same cycle
        d.expired = (q.expired & ~exp_clr) | exp_pulse;
        d.irq_flag = (q.irq_flag & ~irq_clr) | irq_lvl;

        if (wr_status)
        begin
            d.host_en = cfg_wdata[`RCC_HOST_EN_BIT];
            d.card_en = cfg_wdata[`RCC_CARD_EN_BIT];
        end
        if (wr_card)
        begin
            d.ring_en = cfg_wdata[`RCC_RING_EN_BIT];
            d.video_en[cfg_func] = cfg_wdata[`RCC_VIDEO_EN_BIT];
            d.port_sel[cfg_func] = cfg_wdata[`RCC_PORT_SEL_BIT];
            d.aud_en[cfg_func] = cfg_wdata[`RCC_AUDIO_EN_BIT];
            d.spk_en[cfg_func] = cfg_wdata[`RCC_SPK_EN_BIT];
        end

        // read answer one cycle after the strobe; unmapped offsets read zero
        d.rvalid = cfg_rd;
        if (rd_status)
            d.rdata = status_view;
        else if (rd_card)
            d.rdata = card_view;
        else
            d.rdata = 8'h00;

        // ring routing: power pin only when select is zero
        d.ring_out = q.ring_en && q.flt[`RCC_PIN_RING];
        d.power_event = q.ring_en && !ring_pin_select && q.flt[`RCC_PIN_RING];

        // video: pins float in video mode; priority only matters for both
        d.video_hiz = q.video_en;
        if (q.video_en == 2'h3)
        begin
            d.video_sel0 = !q.port_sel[0];
            d.video_sel1 = q.port_sel[0];
        end
        else
        begin
            d.video_sel0 = q.video_en[0];
            d.video_sel1 = q.video_en[1];
        end

        // audio: socket 0 takes precedence when both route
        if (q.aud_en[0])
            d.audio_pwm = aud_lvl[0];
        else if (q.aud_en[1])
            d.audio_pwm = aud_lvl[1];
        else
            d.audio_pwm = 1'b0;

        d.spk_out = spk_gated[0] ^ spk_gated[1];
        d.spk_oe = |q.spk_en;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            q <= '0;
            q.host_en <= `RCC_HOST_EN_RST;
            q.card_en <= `RCC_CARD_EN_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cfg_rdata = q.rdata;
    assign cfg_rvalid = q.rvalid;
    assign power_event_out = q.power_event;
    assign ring_indicate_out = q.ring_out;
    assign video_port_hiz = q.video_hiz;
    assign video_select_0 = q.video_sel0;
    assign video_select_1 = q.video_sel1;
    assign card_audio_pwm_out = q.audio_pwm;
    assign speaker_out_pin = q.spk_out;
    assign speaker_out_oe = q.spk_oe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_exp_set;
        exp_pulse[0] |=> q.expired[0] ##1 q.expired[0] || $past(exp_clr[0]);
    endproperty
    a_exp_set: assert property (p_exp_set) else $error("host expiry not flagged");

    property p_exp_hold;
        q.expired[1] && !exp_clr[1] |=> q.expired[1];
    endproperty
    a_exp_hold: assert property (p_exp_hold) else $error("expired flag lost");

    property p_exp_clear;
        wr_status && cfg_wdata[`RCC_EXP_B_BIT] && !exp_pulse[2] |=> !q.expired[2];
    endproperty
    a_exp_clear: assert property (p_exp_clear) else $error("target B flag not cleared");

    property p_status_view;
        rd_status |=> cfg_rvalid && cfg_rdata[4] == 1'b0 && cfg_rdata[2] == 1'b0 && cfg_rdata[0] == 1'b0
                      && cfg_rdata[7] == $past(q.host_en) && cfg_rdata[3] == $past(q.expired[1]);
    endproperty
    a_status_view: assert property (p_status_view) else $error("status read wrong");

    property p_en_reset;
        @(posedge clk) disable iff (1'b0) !nrst |=> q.host_en && q.card_en && q.expired == 3'h0;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable reset value wrong");

    property p_card_view;
        rd_card |=> cfg_rdata[4:3] == 2'h0 && cfg_rdata[7] == $past(q.ring_en)
                    && cfg_rdata[0] == $past(q.irq_flag[cfg_func]);
    endproperty
    a_card_view: assert property (p_card_view) else $error("card control read wrong");

    property p_ring_gate;
        !q.ring_en |=> !power_event_out && !ring_indicate_out;
    endproperty
    a_ring_gate: assert property (p_ring_gate) else $error("ring routed while disabled");

    property p_ring_shared;
        wr_card |=> q.ring_en == $past(cfg_wdata[`RCC_RING_EN_BIT]);
    endproperty
    a_ring_shared: assert property (p_ring_shared) else $error("ring enable not shared");

    property p_video_prio;
        q.video_en == 2'h3 |=> video_select_0 == !$past(q.port_sel[0])
                               && video_select_1 == $past(q.port_sel[0]) && video_port_hiz == 2'h3;
    endproperty
    a_video_prio: assert property (p_video_prio) else $error("video priority wrong");

    property p_audio_prio;
        q.aud_en == 2'h3 |=> card_audio_pwm_out == $past(aud_lvl[0]);
    endproperty
    a_audio_prio: assert property (p_audio_prio) else $error("socket 0 audio lost priority");

    property p_spk;
        1'b1 |=> speaker_out_oe == |$past(q.spk_en)
                 && speaker_out_pin == ($past(spk_gated[0]) ^ $past(spk_gated[1]));
    endproperty
    a_spk: assert property (p_spk) else $error("speaker output wrong");

    property p_spk_oe;
        q.spk_en == 2'h0 ##1 q.spk_en == 2'h0 |-> !speaker_out_oe;
    endproperty
    a_spk_oe: assert property (p_spk_oe) else $error("speaker driven while disabled");

    property p_irq_set;
        irq_lvl[1] |=> q.irq_flag[1];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("functional irq not flagged");

    property p_irq_hold;
        q.irq_flag[0] && !irq_clr[0] |=> q.irq_flag[0];
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq flag lost");

    c_host_expiry: cover property (exp_pulse[0] ##1 q.expired[0]);
    c_clear_expiry: cover property (q.expired[1] ##1 wr_status ##1 !q.expired[1]);
    c_both_video: cover property (q.video_en == 2'h3 ##1 video_select_1);
    c_speaker_both: cover property (q.spk_en == 2'h3 ##1 speaker_out_oe);

endmodule : rcc_regs

// file: rcc_defs.svh
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define RCC_RETRY_STATUS_OFS 8'h90
`define RCC_CARD_CTRL_OFS 8'h91
`define RCC_RETRY_STATUS_RST 8'hc0
`define RCC_CARD_CTRL_RST 8'h00
`define RCC_HOST_EN_RST 1'b1
`define RCC_CARD_EN_RST 1'b1

// ----------------------------------------------------------------
// retry status field positions
// ----------------------------------------------------------------
`define RCC_HOST_EN_BIT 7
`define RCC_CARD_EN_BIT 6
`define RCC_EXP_B_BIT 5
`define RCC_EXP_A_BIT 3
`define RCC_EXP_HOST_BIT 1

// ----------------------------------------------------------------
// card control field positions
// ----------------------------------------------------------------
`define RCC_RING_EN_BIT 7
`define RCC_VIDEO_EN_BIT 6
`define RCC_PORT_SEL_BIT 5
`define RCC_AUDIO_EN_BIT 2
`define RCC_SPK_EN_BIT 1
`define RCC_IRQ_FLAG_BIT 0

// ----------------------------------------------------------------
// pin vector positions and timing
// ----------------------------------------------------------------
`define RCC_PIN_IRQ 0
`define RCC_PIN_SPK 2
`define RCC_PIN_AUD 4
`define RCC_PIN_RING 6
`define RCC_NUM_PINS 7
`define RCC_RETRY_TIMEOUT_CLKS 32768
`define RCC_RETRY_TIMEOUT_CYC (`RCC_RETRY_TIMEOUT_CLKS / 1)

`endif

// file: rcc_pkg.sv
`include "rcc_defs.svh"

package rcc_pkg;

    typedef logic [15:0] rcc_cnt_t;
    typedef logic [`RCC_NUM_PINS-1:0] rcc_pins_t;

    typedef struct packed {
        logic run;
        rcc_cnt_t cnt;
        logic expire;
    } rcc_timer_s;

    typedef struct packed {
        logic host_en;
        logic card_en;
        logic [2:0] expired;
        logic ring_en;
        logic [1:0] video_en;
        logic [1:0] port_sel;
        logic [1:0] aud_en;
        logic [1:0] spk_en;
        logic [1:0] irq_flag;
        rcc_pins_t sync1;
        rcc_pins_t sync2;
        rcc_pins_t sync3;
        rcc_pins_t flt;
        logic [7:0] rdata;
        logic rvalid;
        logic power_event;
        logic ring_out;
        logic [1:0] video_hiz;
        logic video_sel0;
        logic video_sel1;
        logic audio_pwm;
        logic spk_out;
        logic spk_oe;
    } rcc_state_s;

endpackage : rcc_pkg

// file: rcc_retry_timer.sv
`include "rcc_defs.svh"

module rcc_retry_timer
    import rcc_pkg::*;
#(
    parameter int unsigned LIMIT = `RCC_RETRY_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic retry_issue,
    input wire logic master_back,
    output logic expire
);

    rcc_timer_s q, d;

    always_comb
    begin
        d = q;
        d.expire = 1'b0;
        if (!enable)
        begin
            d.run = 1'b0;
            d.cnt = '0;
        end
        else if (master_back)
        begin
            d.run = 1'b0;
            d.cnt = '0;
        end
        else if (retry_issue)
        begin
            d.run = 1'b1;
            d.cnt = '0;
        end
        else if (q.run)
        begin
            if (q.cnt == rcc_cnt_t'(LIMIT - 1))
            begin
                d.expire = 1'b1;
                d.run = 1'b0;
                d.cnt = '0;
            end
            else
            begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= d;
    end

    assign expire = q.expire;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_timer_idle;
        !enable |=> (q.cnt == '0) && !q.run && !expire;
    endproperty
    a_timer_idle: assert property (p_timer_idle) else $error("timer ran while disabled");

    property p_timer_limit;
        expire |-> $past(q.cnt) == rcc_cnt_t'(LIMIT - 1) && $past(q.run);
    endproperty
    a_timer_limit: assert property (p_timer_limit) else $error("expiry at wrong count");

endmodule : rcc_retry_timer

// file: rcc_master_model.sv
module rcc_master_model
    import rcc_pkg::*;
(
    input wire logic clk,
    output logic [2:0] retry_issue,
    output logic [2:0] master_back
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        retry_issue = 3'h0;
        master_back = 3'h0;
    end

    // one retried master; back_after of zero means it never comes back
    task automatic retry(input int idx, input int back_after);
        @(negedge clk);
        retry_issue[idx] = 1'b1;
        @(negedge clk);
        retry_issue[idx] = 1'b0;
        if (back_after > 0)
        begin
            repeat (back_after - 1) @(negedge clk);
            master_back[idx] = 1'b1;
            @(negedge clk);
            master_back[idx] = 1'b0;
        end
    endtask : retry
endmodule : rcc_master_model

// file: rcc_regs_bench.sv
module rcc_regs_bench
    import rcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // short count keeps the run small; expectations follow it
    localparam int LIMIT = 16;

    logic clk, nrst, cfg_func, cfg_wr, cfg_rd, cfg_rvalid;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
    logic [2:0] retry_issue, master_back;
    logic [1:0] card_irq_in, card_speaker_in, card_audio_in, video_port_hiz;
    logic ring_in, ring_pin_select, power_event_out, ring_indicate_out;
    logic video_select_0, video_select_1, card_audio_pwm_out, speaker_out_pin, speaker_out_oe;
    logic [1:0] en_m;
    logic [2:0] exp_m;
    logic ring_m;
    logic [7:0] ctl_m [2];
    logic [1:0] irq_m;
    int mismatches;
    int checks;
    int cycles;

    rcc_regs #(.RETRY_LIMIT(LIMIT)) uut (.clk(clk), .nrst(nrst), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .retry_issue(retry_issue), .master_back(master_back), .card_irq_in(card_irq_in),
        .card_speaker_in(card_speaker_in), .card_audio_in(card_audio_in), .ring_in(ring_in),
        .ring_pin_select(ring_pin_select), .power_event_out(power_event_out), .ring_indicate_out(ring_indicate_out),
        .video_port_hiz(video_port_hiz), .video_select_0(video_select_0), .video_select_1(video_select_1),
        .card_audio_pwm_out(card_audio_pwm_out), .speaker_out_pin(speaker_out_pin),
        .speaker_out_oe(speaker_out_oe));

    rcc_master_model master (.clk(clk), .retry_issue(retry_issue), .master_back(master_back));

    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: read 0x%h, expected 0x%h", $time, got, want);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic want, input string what);
        checks++;
        if (got !== want)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s is %b, expected %b", $time, what, got, want);
        end
    endtask : chk_pin

    // ----------------------------------------------------------------
    // reference model and bus tasks, entered at a falling edge
    // ----------------------------------------------------------------
    function automatic logic [7:0] exp90();
        return {en_m, exp_m[2], 1'b0, exp_m[1], 1'b0, exp_m[0], 1'b0};
    endfunction : exp90

    function automatic logic [7:0] exp91(input int f);
        return {ring_m, ctl_m[f][6:5], 2'b00, ctl_m[f][2:1], irq_m[f]};
    endfunction : exp91

    task automatic wr(input logic f, input logic [7:0] a, input logic [7:0] d);
        cfg_func = f;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        if (a == 8'h90)
        begin
            en_m = d[7:6];
            exp_m = exp_m & ~{d[5], d[3], d[1]};
        end
        else if (a == 8'h91)
        begin
            ring_m = d[7];
            ctl_m[f] = d & 8'h66;
            if (d[0])
                irq_m[f] = 1'b0;
        end
        // idle cycle: a following call never re-raises the strobe in the same step
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic f, input logic [7:0] a, input logic [7:0] want);
        cfg_func = f;
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        chk_pin(cfg_rvalid, 1'b1, "rvalid");
        chk_reg(cfg_rdata, want);
        @(negedge clk);
    endtask : rd

    task automatic chk_pins();
        logic [1:0] sp;
        sp = card_speaker_in & {ctl_m[1][1], ctl_m[0][1]};
        chk_pin(speaker_out_oe, ctl_m[0][1] | ctl_m[1][1], "spk oe");
        chk_pin(speaker_out_pin, ^sp, "spk");
        chk_pin(card_audio_pwm_out, ctl_m[0][2] ? card_audio_in[0] : ctl_m[1][2] & card_audio_in[1], "aud");
        chk_pin(video_port_hiz[0], ctl_m[0][6], "hiz0");
        chk_pin(video_port_hiz[1], ctl_m[1][6], "hiz1");
        if (ctl_m[0][6] & ctl_m[1][6])
        begin
            chk_pin(video_select_0, ~ctl_m[0][5], "sel0");
            chk_pin(video_select_1, ctl_m[0][5], "sel1");
        end
        chk_pin(power_event_out, ring_m & ring_in & ~ring_pin_select, "pwr");
        chk_pin(ring_indicate_out, ring_m & ring_in, "ring");
    endtask : chk_pins

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {clk, nrst, cfg_func, cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = '0;
        {card_irq_in, card_speaker_in, card_audio_in, ring_in, ring_pin_select} = '0;
        {mismatches, checks, cycles} = '0;
        en_m = 2'b11;
        {exp_m, ring_m, irq_m} = '0;
        ctl_m[0] = 8'h00;
        ctl_m[1] = 8'h00;
        void'($urandom(85));
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        rd(0, 8'h90, exp90());
        rd(0, 8'h91, exp91(0));
        rd(1, 8'h91, exp91(1));
        rd(0, 8'h97, 8'h00);
        chk_pin(speaker_out_oe, 1'b0, "spk oe");
        // status is reached through function 0 only
        for (int i = 0; i < 3; i++)
        begin
            master.retry(i, 0);
            repeat (LIMIT + 6) @(negedge clk);
            exp_m[i] = 1'b1;
            rd(0, 8'h90, exp90());
            repeat (LIMIT) @(negedge clk);
            rd(0, 8'h90, exp90());
        end
        wr(0, 8'h90, 8'hff);
        rd(0, 8'h90, exp90());
        master.retry(1, LIMIT - 4);
        master.retry(0, LIMIT - 2);
        repeat (LIMIT + 6) @(negedge clk);
        rd(0, 8'h90, exp90());
        wr(0, 8'h90, 8'h00);
        master.retry(0, 0);
        master.retry(2, 0);
        repeat (LIMIT + 6) @(negedge clk);
        rd(0, 8'h90, exp90());
        wr(0, 8'h90, 8'h40);
        master.retry(0, 0);
        master.retry(1, 0);
        repeat (LIMIT + 6) @(negedge clk);
        exp_m[1] = 1'b1;
        rd(0, 8'h90, exp90());
        wr(0, 8'h90, 8'hc8);
        rd(0, 8'h90, exp90());
        // random feature settings; first rounds force both sockets on
        for (int k = 0; k < 12; k++)
        begin
            wr(0, 8'h91, 8'($urandom) | (k < 3 ? 8'h46 : 8'h00));
            wr(1, 8'h91, 8'($urandom) | (k < 3 ? 8'h46 : 8'h00));
            {card_speaker_in, card_audio_in, ring_in, ring_pin_select} = 6'($urandom);
            repeat (8) @(negedge clk);
            chk_pins();
            rd(0, 8'h91, exp91(0));
            rd(1, 8'h91, exp91(1));
        end
        for (int s = 0; s < 2; s++)
        begin
            card_irq_in[s] = 1'b1;
            repeat (8) @(negedge clk);
            card_irq_in[s] = 1'b0;
            repeat (8) @(negedge clk);
            irq_m[s] = 1'b1;
            rd(s[0], 8'h91, exp91(s));
            rd(~s[0], 8'h91, exp91(1 - s));
            wr(s[0], 8'h91, 8'h01);
            rd(s[0], 8'h91, exp91(s));
        end
        finish_test();
    end
endmodule : rcc_regs_bench
